// ===== pirq_pkg.sv
// Package for the port interrupt request controller.
// Holds register offsets, field positions, reset values and vector addresses.
package pirq_pkg;
	localparam logic [11:0] PIRQ_ADDR_REQ_A   = 12'hFC3; // Port A request register
	localparam logic [11:0] PIRQ_ADDR_REQ_B   = 12'hFC4; // Second request register
	localparam logic [11:0] PIRQ_ADDR_CTRL    = 12'hFCF; // Interrupt control register
	localparam logic [11:0] PIRQ_ADDR_EDGE    = 12'hFCD; // Edge select for port A pins
	localparam logic [11:0] PIRQ_ADDR_MODE    = 12'hFCE; // Both-edge mode for port A pins
	localparam logic [11:0] PIRQ_ADDR_STAT    = 12'hFD0; // Sticky event status
	localparam logic [11:0] PIRQ_ADDR_MASK    = 12'hFD1; // Event mask
	localparam int          PIRQ_CTRL_GIE_BIT = 7;       // Global enable bit position
	localparam logic [7:0]  PIRQ_REQ_RST      = 8'h00;
	localparam logic [7:0]  PIRQ_CFG_RST      = 8'h00;
	localparam logic [15:0] PIRQ_VEC_BASE_A   = 16'h0016; // Vector of port A pin 7
	localparam logic [15:0] PIRQ_VEC_BASE_B   = 16'h0026; // Vector of second register bit 7
	localparam logic [15:0] PIRQ_VEC_PC0      = 16'h0036; // Lowest priority source
	localparam logic [15:0] PIRQ_VEC_RSVD     = 16'h0038; // Reserved slot, never issued
	localparam logic [15:0] PIRQ_VEC_STEP     = 16'h0002;
	localparam int          PIRQ_PC0_BIT      = 0;       // Port C pin 0 in second register
	localparam int          PIRQ_STAT_DELIV   = 0;       // Status: a vector was taken
	localparam int          PIRQ_STAT_POLL    = 1;       // Status: request while disabled
endpackage : pirq_pkg

// ===== pirq_edge_if.sv
// Interface between the top and its edge detector.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface pirq_edge_if;
	logic [15:0] pins;      // Pin levels, port A in low byte
	logic [7:0]  edge_sel;  // 1 selects rising edge, port A pins
	logic [7:0]  both_mode; // 1 selects both edges, port A pins
	logic [15:0] events;    // One-cycle request pulses

	modport top (output pins, output edge_sel, output both_mode, input events);
	modport det (input pins, input edge_sel, input both_mode, output events);
endinterface : pirq_edge_if

// ===== pirq_edge_det.sv
// Edge detector for the request sources.
// Assumes pin levels are synchronous to clk.
`timescale 1ns/100ps
module pirq_edge_det
	import pirq_pkg::*;
(
	// System
	input  wire logic  clk,
	input  wire logic  sys_rst,
	// Sources
	pirq_edge_if.det   eif
);
	logic [15:0] last_q;
	logic [15:0] last_d;
	logic [15:0] ev_q;
	logic [15:0] ev_d;

	// Detect edges; second register sources always use both edges
	always_comb
	begin
		last_d = eif.pins;
		for (int i = 0; i < 16; i++)
		begin
			if (i >= 8 || eif.both_mode[i[2:0]])
				ev_d[i] = last_q[i] ^ eif.pins[i];
			else if (eif.edge_sel[i[2:0]])
				ev_d[i] = ~last_q[i] & eif.pins[i];
			else
				ev_d[i] = last_q[i] & ~eif.pins[i];
		end
	end

	// Register level history and pulses
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			last_q <= 16'h0000;
			ev_q   <= 16'h0000;
		end
		else
		begin
			last_q <= last_d;
			ev_q   <= ev_d;
		end
	end

	assign eif.events = ev_q;
endmodule : pirq_edge_det

// ===== pirq_ctrl.sv
// Port interrupt request controller: request capture, global enable, vectoring.
// Assumes a core that pulses ei/irq_return_instruction, and acknowledges a vector with irq_ack.
`timescale 1ns/100ps
module pirq_ctrl
	import pirq_pkg::*;
(
	// System
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Sources
	input  wire logic [7:0]  port_a_pins,
	input  wire logic        comparator_req,
	input  wire logic [7:0]  second_srcs,
	// Core side
	input  wire logic        enable_irq_instruction,
	input  wire logic        irq_return_instruction,
	input  wire logic        irq_ack,
	output logic             core_irq_req,
	output logic      [15:0] core_irq_vector,
	// Interrupt output
	output logic             irq_out
);
	typedef enum logic [2:0]
	{
		PIRQ_IDLE = 3'b001,
		PIRQ_REQ  = 3'b010,
		PIRQ_TAKE = 3'b100
	} pirq_state_e;

	pirq_edge_if eif ();

	logic [7:0]  req_a_q, req_a_d;
	logic [7:0]  req_b_q, req_b_d;
	logic        gie_q, gie_d;
	logic [7:0]  edge_q, edge_d;
	logic [7:0]  mode_q, mode_d;
	logic [1:0]  stat_q, stat_d;
	logic [1:0]  mask_q, mask_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        cmp_last_q;
	pirq_state_e st_q, st_d;
	logic        ireq_q, ireq_d;
	logic [15:0] vec_q, vec_d;
	logic [3:0]  sel_q, sel_d;
	logic        irq_q, irq_d;
	logic [15:0] set_vec;
	logic        any_pend;
	logic [3:0]  top_idx;
	logic        deliv_ev;
	logic        poll_ev;

	// Highest set bit of the combined pending vector, bit 15 first
	function automatic logic [3:0] pirq_top(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++)
		begin
			if (v[i])
				idx = i[3:0];
		end
		return idx;
	endfunction : pirq_top

	// Vector for a combined index: port A high, second register next
	function automatic logic [15:0] pirq_vec(input logic [3:0] idx);
		logic [15:0] v;
		if (idx[3])
			v = PIRQ_VEC_BASE_A + PIRQ_VEC_STEP * {12'h000, 4'h7 - {1'b0, idx[2:0]}};
		// Base plus step stops one slot short, so the lowest source is mapped by hand
		else if (idx[2:0] == 3'(PIRQ_PC0_BIT))
			v = PIRQ_VEC_PC0;
		else
			v = PIRQ_VEC_BASE_B + PIRQ_VEC_STEP * {12'h000, 4'h7 - {1'b0, idx[2:0]}};
		return v;
	endfunction : pirq_vec

	pirq_edge_det u_edge
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.eif     (eif.det)
	);

	assign eif.pins      = {second_srcs, port_a_pins};
	assign eif.edge_sel  = edge_q;
	assign eif.both_mode = mode_q;

	// Request sets: comparator joins bit 6 on its rising edge
	always_comb
	begin
		set_vec     = eif.events;
		set_vec[6]  = eif.events[6] | (comparator_req & ~cmp_last_q);
		any_pend    = |{req_b_q, req_a_q};
		top_idx     = pirq_top({req_a_q, req_b_q});
	end

	// Request registers, control and configuration
	always_comb
	begin
		req_a_d  = req_a_q;
		req_b_d  = req_b_q;
		gie_d    = gie_q;
		edge_d   = edge_q;
		mode_d   = mode_q;
		mask_d   = mask_q;
		if (reg_wr)
		begin
			unique case (reg_addr)
				PIRQ_ADDR_REQ_A: req_a_d = reg_wdata;
				PIRQ_ADDR_REQ_B: req_b_d = reg_wdata;
				PIRQ_ADDR_CTRL:  gie_d   = reg_wdata[PIRQ_CTRL_GIE_BIT];
				PIRQ_ADDR_EDGE:  edge_d  = reg_wdata;
				PIRQ_ADDR_MODE:  mode_d  = reg_wdata;
				PIRQ_ADDR_MASK:  mask_d  = reg_wdata[1:0];
				default:         ;
			endcase
		end
		// Taken request clears its pending bit
		if (st_q == PIRQ_TAKE)
		begin
			if (sel_q[3])
				req_a_d[sel_q[2:0]] = 1'b0;
			else
				req_b_d[sel_q[2:0]] = 1'b0;
		end
		if (enable_irq_instruction || irq_return_instruction)
			gie_d = 1'b1;
		// Sets come last so an event beside a clear survives
		req_a_d = req_a_d | set_vec[7:0];
		req_b_d = req_b_d | set_vec[15:8];
	end

	// Delivery machine toward the core
	always_comb
	begin
		st_d     = st_q;
		ireq_d   = ireq_q;
		vec_d    = vec_q;
		sel_d    = sel_q;
		deliv_ev = 1'b0;
		unique case (st_q)
			PIRQ_IDLE:
			begin
				if (gie_q && any_pend)
				begin
					st_d   = PIRQ_REQ;
					ireq_d = 1'b1;
					sel_d  = top_idx;
					vec_d  = pirq_vec(top_idx);
				end
			end
			PIRQ_REQ:
			begin
				if (!gie_q)
				begin
					st_d   = PIRQ_IDLE;
					ireq_d = 1'b0;
				end
				else if (irq_ack)
				begin
					st_d     = PIRQ_TAKE;
					ireq_d   = 1'b0;
					deliv_ev = 1'b1;
				end
				else
				begin
					sel_d = top_idx;
					vec_d = pirq_vec(top_idx);
				end
			end
			PIRQ_TAKE:
			begin
				st_d = PIRQ_IDLE;
			end
		endcase
	end

	// Sticky status, write one to clear, set wins
	always_comb
	begin
		poll_ev = ~gie_q & (|set_vec);
		stat_d  = stat_q;
		if (reg_wr && reg_addr == PIRQ_ADDR_STAT)
			stat_d = stat_q & ~reg_wdata[1:0];
		stat_d[PIRQ_STAT_DELIV] = stat_d[PIRQ_STAT_DELIV] | deliv_ev;
		stat_d[PIRQ_STAT_POLL]  = stat_d[PIRQ_STAT_POLL] | poll_ev;
		irq_d = |(stat_d & mask_q);
	end

	// Read data, valid the cycle after the strobe only
	always_comb
	begin
		rdata_d = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				PIRQ_ADDR_REQ_A: rdata_d = req_a_q;
				PIRQ_ADDR_REQ_B: rdata_d = req_b_q;
				PIRQ_ADDR_CTRL:  rdata_d = {gie_q, 7'h00};
				PIRQ_ADDR_EDGE:  rdata_d = edge_q;
				PIRQ_ADDR_MODE:  rdata_d = mode_q;
				PIRQ_ADDR_STAT:  rdata_d = {6'h00, stat_q};
				PIRQ_ADDR_MASK:  rdata_d = {6'h00, mask_q};
				default:         rdata_d = 8'h00;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			req_a_q    <= PIRQ_REQ_RST;
			req_b_q    <= PIRQ_REQ_RST;
			gie_q      <= 1'b0;
			edge_q     <= PIRQ_CFG_RST;
			mode_q     <= PIRQ_CFG_RST;
			stat_q     <= 2'h0;
			mask_q     <= 2'h0;
			rdata_q    <= 8'h00;
			cmp_last_q <= 1'b0;
			st_q       <= PIRQ_IDLE;
			ireq_q     <= 1'b0;
			vec_q      <= 16'h0000;
			sel_q      <= 4'h0;
			irq_q      <= 1'b0;
		end
		else
		begin
			req_a_q    <= req_a_d;
			req_b_q    <= req_b_d;
			gie_q      <= gie_d;
			edge_q     <= edge_d;
			mode_q     <= mode_d;
			stat_q     <= stat_d;
			mask_q     <= mask_d;
			rdata_q    <= rdata_d;
			cmp_last_q <= comparator_req;
			st_q       <= st_d;
			ireq_q     <= ireq_d;
			vec_q      <= vec_d;
			sel_q      <= sel_d;
			irq_q      <= irq_d;
		end
	end

	assign reg_rdata       = rdata_q;
	assign core_irq_req    = ireq_q;
	assign core_irq_vector = vec_q;
	assign irq_out         = irq_q;
endmodule : pirq_ctrl

// ===== pirq_ctrl_properties.sv
// Checker of the port request controller, seeing only its top ports.
// Assumes one clock and a synchronous, active high reset.
`timescale 1ns/100ps
module pirq_ctrl_chk
	import pirq_pkg::*;
(
	// System
	input wire logic        clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// Core side
	input wire logic        irq_ack,
	input wire logic        core_irq_req,
	input wire logic [15:0] core_irq_vector,
	input wire logic        irq_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic mapped;
	// Decoded register map, used to spot reads of holes
	assign mapped = reg_addr inside {[PIRQ_ADDR_REQ_A:PIRQ_ADDR_REQ_B], [PIRQ_ADDR_EDGE:PIRQ_ADDR_MASK]};

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	unmapped_rd_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("hole read not zero");
	reset_quiet_a: assert property ($past(sys_rst) |-> !core_irq_req && !irq_out)
		else $error("output active after reset");
	ack_drop_a: assert property (irq_ack && core_irq_req |=> !core_irq_req)
		else $error("request kept after ack");
	vec_legal_a: assert property (core_irq_req |->
		core_irq_vector inside {[PIRQ_VEC_BASE_A:PIRQ_VEC_PC0]} && !core_irq_vector[0])
		else $error("illegal vector");
	vec_prio_a: assert property (core_irq_req && $past(core_irq_req) |->
		core_irq_vector <= $past(core_irq_vector))
		else $error("vector lost priority");
	req_hold_a: assert property ($fell(core_irq_req) |-> $past(irq_ack) || $past(reg_wr) || $past(reg_wr, 2))
		else $error("request dropped unasked");
	gie_off_a: assert property (reg_wr && reg_addr == PIRQ_ADDR_CTRL && !reg_wdata[PIRQ_CTRL_GIE_BIT]
		|-> ##2 !core_irq_req)
		else $error("request while disabled");
endmodule : pirq_ctrl_chk

bind pirq_ctrl pirq_ctrl_chk i_pirq_ctrl_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
	.core_irq_req(core_irq_req), .core_irq_vector(core_irq_vector), .irq_out(irq_out));

// ===== pirq_core_model.sv
// Core model: takes vectored requests and acknowledges them.
// Assumes the controller holds its request until acknowledged.
`timescale 1ns/100ps
module pirq_core_model
(
	// System
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Controller side
	input  wire logic       core_irq_req,
	input  wire logic [2:0] ack_dly,
	output logic            irq_ack
);
	logic [2:0] wait_q;
	// Ack after ack_dly cycles; polled mode is left to the bench reads
	always_ff @(posedge clk)
	begin
		if (sys_rst || !core_irq_req || irq_ack)
		begin
			wait_q  <= 3'h0;
			irq_ack <= 1'h0;
		end
		else if (wait_q == ack_dly)
			irq_ack <= 1'h1;
		else
			wait_q <= wait_q + 3'h1;
	end
endmodule : pirq_core_model

// ===== tb_pirq_ctrl.sv
// Testbench of the port request controller with a core model.
// Assumes one 40 MHz clock and the vectors of the package.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_pirq_ctrl;
	import pirq_pkg::*;
	logic        clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, comparator_req = 1'h0;
	logic        enable_irq_instruction = 1'h0, irq_return_instruction = 1'h0, irq_ack, core_irq_req, irq_out;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0]  reg_wdata = 8'h00, port_a_pins = 8'h00, second_srcs = 8'h00, reg_rdata;
	logic [15:0] core_irq_vector;
	logic [2:0]  ack_dly = 3'h0;
	int          n_mismatch = 0, samples_checked = 0;
	// Device and core model
	pirq_ctrl i_pirq_ctrl (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_a_pins,
		.comparator_req, .second_srcs, .enable_irq_instruction, .irq_return_instruction, .irq_ack,
		.core_irq_req, .core_irq_vector, .irq_out);
	pirq_core_model i_pirq_core_model (.clk, .sys_rst, .core_irq_req, .ack_dly, .irq_ack);
	always #12.5 clk = ~clk;

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd_chk
	// Bounded wait for a request, then for its drop after the ack
	task automatic wait_vec(input logic [15:0] e);
		int k;
		for (k = 0; k < 20 && core_irq_req !== 1'h1; k++)
			@(posedge clk) #1;
		`CHK(core_irq_req, 1'h1)
		`CHK(core_irq_vector, e)
		for (k = 0; k < 20 && core_irq_req !== 1'h0; k++)
			@(posedge clk) #1;
		`CHK(core_irq_req, 1'h0)
	endtask : wait_vec
	task automatic t_regs;
		rd_chk(PIRQ_ADDR_REQ_A, 8'h00);
		rd_chk(PIRQ_ADDR_CTRL, 8'h00);
		wr(PIRQ_ADDR_REQ_A, 8'hA5);
		rd_chk(PIRQ_ADDR_REQ_A, 8'hA5);
		wr(PIRQ_ADDR_REQ_A, 8'h00);
		rd_chk(12'hFFF, 8'h00);
	endtask : t_regs
	// Two sources pend while disabled, then both are taken in order
	task automatic t_vec;
		wr(PIRQ_ADDR_MODE, 8'h80);
		ack_dly <= 3'h5;
		@(posedge clk);
		port_a_pins[7] <= 1'h1;
		second_srcs[0] <= 1'h1;
		repeat (3) @(posedge clk);
		rd_chk(PIRQ_ADDR_REQ_A, 8'h80);
		rd_chk(PIRQ_ADDR_REQ_B, 8'h01);
		`CHK(core_irq_req, 1'h0)
		@(posedge clk);
		enable_irq_instruction <= 1'h1;
		@(posedge clk);
		enable_irq_instruction <= 1'h0;
		wait_vec(PIRQ_VEC_BASE_A);
		wait_vec(PIRQ_VEC_PC0);
		rd_chk(PIRQ_ADDR_REQ_A, 8'h00);
	endtask : t_vec
	// Falling edge pends while disabled; return instruction re-enables
	task automatic t_irq_return_instruction;
		wr(PIRQ_ADDR_CTRL, 8'h00);
		ack_dly        <= 3'h0;
		second_srcs[0] <= 1'h0;
		repeat (3) @(posedge clk);
		`CHK(core_irq_req, 1'h0)
		irq_return_instruction <= 1'h1;
		@(posedge clk);
		irq_return_instruction <= 1'h0;
		wait_vec(PIRQ_VEC_PC0);
		rd_chk(PIRQ_ADDR_REQ_B, 8'h00);
	endtask : t_irq_return_instruction
	// Rising edge selected, polled status raises the masked output
	task automatic t_poll;
		wr(PIRQ_ADDR_CTRL, 8'h00);
		wr(PIRQ_ADDR_STAT, 8'h03);
		wr(PIRQ_ADDR_MASK, 8'h02);
		wr(PIRQ_ADDR_EDGE, 8'h08);
		port_a_pins[3] <= 1'h1;
		comparator_req <= 1'h1;
		repeat (3) @(posedge clk);
		rd_chk(PIRQ_ADDR_REQ_A, 8'h48);
		`CHK(irq_out, 1'h1)
		wr(PIRQ_ADDR_STAT, 8'h02);
		repeat (2) @(posedge clk);
		`CHK(irq_out, 1'h0)
		wr(PIRQ_ADDR_REQ_A, 8'h00);
		port_a_pins[3] <= 1'h0;
		port_a_pins[2] <= 1'h1;
		repeat (3) @(posedge clk);
		rd_chk(PIRQ_ADDR_REQ_A, 8'h00);
		// Pin 2 keeps the falling edge selected by reset
		@(posedge clk);
		port_a_pins[2] <= 1'h0;
		repeat (3) @(posedge clk);
		rd_chk(PIRQ_ADDR_REQ_A, 8'h04);
	endtask : t_poll
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'h0;
		t_regs();
		t_vec();
		t_irq_return_instruction();
		t_poll();
		give_verdict();
	end
	// Watchdog, far beyond the hundred or so cycles the tests need
	initial
	begin
		#(2000 * 25);
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_pirq_ctrl
